//--- common/ees_pkg.sv
package ees_pkg;

  // Control byte layout and the code that selects this slave.
  localparam logic [3:0] CTRL_CODE     = 4'ha;
  localparam int         CTRL_CODE_MSB = 7;
  localparam int         CTRL_CODE_LSB = 4;
  localparam int         CTRL_RW_BIT   = 0;

  // Word address and page geometry.
  localparam int ADDR_W     = 7;
  localparam int IDX_W      = 3;
  localparam int PAGE_W     = ADDR_W - IDX_W;
  localparam int PAGE_BYTES = 8;
  localparam int BYTE_W     = 8;

  // Bit counter values within one byte frame, and the end value of the commit index.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_BIT_NUM   = 4'h9;
  localparam logic [3:0] COMMIT_DONE   = 4'h8;

  // Internal write cycle, longest time rounded down to clock cycles.
  localparam int MCLK_HZ       = 100_000_000;
  localparam int WRITE_TIME_MS = 5;
  localparam int WRITE_CYCLES  = (WRITE_TIME_MS * (MCLK_HZ / 1000));
  localparam int TIMER_W       = 20;

  // Reset values.
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

  // Bus protocol state of the slave.
  typedef enum logic [2:0] {
    EES_IDLE,
    EES_CTRL,
    EES_ADDR,
    EES_DATA,
    EES_READ,
    EES_IGNORE
  } ees_state_t;

endpackage

//--- logic/ees_sync.sv
`timescale 1ns/100ps
`default_nettype none

module ees_sync
  import ees_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable.
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // Two flip-flops per bit; only the second stage is visible outside.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else if (ce_i) begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;

endmodule // ees_sync

`default_nettype wire

//--- logic/ees_slave.sv
`timescale 1ns/100ps
`default_nettype none

module ees_slave
  import ees_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // System clock, reset and enable.
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Two-wire bus; SCL arrives both as link clock and as a level.
  input  wire logic              scl_clk_i,
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  // Write-protect pin.
  input  wire logic              wp_i,
  // Array write port and shared state.
  output logic                   wr_en_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [BYTE_W-1:0]      wr_data_o,
  output logic [ADDR_W-1:0]      addr_ptr_o,
  output logic                   busy_o
);

  // The slave is built in two clock domains. Only the eight-bit shift
  // register runs on the bus clock. Every decision, the acknowledge, the
  // page buffer and the write cycle run on the system clock. They see the
  // bus lines only through the two-stage synchroniser, so a bus edge is
  // acted on three system cycles late. At bus rates up to 1 MHz that delay
  // is small against either phase of SCL.

  // True in states where the slave counts bits of a received byte.
  function automatic logic rx_state(input ees_state_t st);
    rx_state = (st == EES_CTRL) || (st == EES_ADDR) || (st == EES_DATA);
  endfunction

  // Pin synchronisers and previous levels. The previous levels start high,
  // matching an idle bus, so that leaving reset on an idle bus cannot look
  // like a Start or a Stop.
  // Pin synchronisers and previous levels.
  logic [2:0]        pin_s;
  logic              scl_s;
  logic              sda_s;
  logic              wp_s;
  logic              scl_prev_reg;
  logic              sda_prev_reg;

  // Link-domain shift register.
  logic [BYTE_W-1:0] link_shift_reg;

  // Protocol state.
  ees_state_t        state_reg;
  logic [3:0]        bit_cnt_reg;
  logic              ack_phase_reg;
  logic              sda_oe_reg;
  logic              sda_out_reg;

  // Page buffer and pointer.
  logic [BYTE_W-1:0]     page_mem_reg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] slot_valid_reg;
  logic [ADDR_W-1:0]     addr_ptr_reg;

  // Write cycle.
  logic                  busy_reg;
  logic [TIMER_W-1:0]    timer_reg;
  logic [3:0]            commit_idx_reg;
  logic                  wr_en_reg;
  logic [ADDR_W-1:0]     wr_addr_reg;
  logic [BYTE_W-1:0]     wr_data_reg;

  // Bus events.
  logic              start_det;
  logic              stop_det;
  logic              scl_rise;
  logic              scl_fall;
  logic              byte_done;
  logic              ctrl_match;
  logic              write_go;
  logic [BYTE_W-1:0] rx_byte;

  // All three pins come from outside the system clock domain. They share
  // one synchroniser so that SCL and SDA stay aligned with each other.
  // Without that alignment a data change just after a fall of SCL could
  // be taken for a Start or a Stop. The synchroniser presets high, so
  // write-protect reads as set until the first real samples arrive.
  ees_sync #(
    .WIDTH (3)
  ) u_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .d_i     ({scl_i, sda_i, wp_i}),
    .q_o     (pin_s)
  );

  assign scl_s = pin_s[2];
  assign sda_s = pin_s[1];
  assign wp_s  = pin_s[0];

  // This register has no reset and ignores the clock enable. Any stale
  // contents are shifted out by the eight data bits that follow the
  // next Start. The byte is read only once it is complete.
  // It also shifts during the acknowledge pulse. That is harmless, because
  // the byte has already been taken by then.
  // Data bits are shifted in on each rising SCL edge in the link domain.
  always_ff @(posedge scl_clk_i) begin
    link_shift_reg <= {link_shift_reg[BYTE_W-2:0], sda_i};
  end

  // The shift register is stable through SCL low, so it is read only after
  // the synchronised falling edge; the next rising edge is far away.
  assign rx_byte = link_shift_reg;

  // Previous synchronised levels for edge and condition detection.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (ce_i) begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  // Both conditions need SCL high on two successive samples. This keeps
  // an SDA change that lands close to an SCL edge from being taken as a
  // condition.
  // A Start takes priority over everything else in the sequencer. Because
  // of that, a repeated Start always resynchronises the slave.
  // Start and Stop are SDA edges while SCL stays high.
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign scl_rise  = scl_s && !scl_prev_reg;
  assign scl_fall  = !scl_s && scl_prev_reg;

  // A byte is complete at the falling edge after its eighth rising edge.
  assign byte_done = scl_fall && rx_state(state_reg) && !ack_phase_reg &&
                     (bit_cnt_reg == BITS_PER_BYTE);
  assign ctrl_match = (rx_byte[CTRL_CODE_MSB:CTRL_CODE_LSB] == CTRL_CODE);
  assign write_go   = stop_det && (state_reg == EES_DATA) && (|slot_valid_reg) &&
                      !wp_s && !busy_reg;

  // The bit counter stops at nine, so a long read does not wrap it.
  // The acknowledge enable changes only just after a fall of SCL. It is
  // raised after the eighth fall and dropped after the ninth.
  // A busy write cycle or a foreign control code sends the slave to the
  // ignore state. It stays there, leaving SDA released, until the next
  // Start or Stop.
  // Protocol sequencer: bit counting, acknowledge and state changes.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg     <= EES_IDLE;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
    end else if (ce_i) begin
      if (start_det) begin
        state_reg     <= EES_CTRL;
        bit_cnt_reg   <= 4'h0;
        ack_phase_reg <= 1'b0;
        sda_oe_reg    <= 1'b0;
      end else if (stop_det) begin
        state_reg     <= EES_IDLE;
        ack_phase_reg <= 1'b0;
        sda_oe_reg    <= 1'b0;
      end else if (scl_rise && (rx_state(state_reg) || state_reg == EES_READ) &&
                   (bit_cnt_reg < ACK_BIT_NUM)) begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (byte_done) begin
        // The acknowledge is driven from just after SCL falls, so it is
        // already low before and through the whole ninth high phase.
        ack_phase_reg <= 1'b1;
        case (state_reg)
          EES_CTRL: begin
            if (ctrl_match && !busy_reg) begin
              sda_oe_reg <= 1'b1;
              state_reg  <= rx_byte[CTRL_RW_BIT] ? EES_READ : EES_ADDR;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg  <= EES_IGNORE;
            end
          end
          EES_ADDR: begin
            sda_oe_reg <= 1'b1;
            state_reg  <= EES_DATA;
          end
          EES_DATA: begin
            sda_oe_reg <= 1'b1;
          end
          default: begin
            sda_oe_reg <= 1'b0;
          end
        endcase
      end else if (scl_fall && ack_phase_reg && (bit_cnt_reg == ACK_BIT_NUM)) begin
        // Release after the ninth pulse; no read data is driven.
        sda_oe_reg    <= 1'b0;
        ack_phase_reg <= 1'b0;
        bit_cnt_reg   <= 4'h0;
      end
    end
  end

  // Open-drain output: data is always low, the enable decides.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sda_out_reg <= 1'b0;
    end else if (ce_i) begin
      sda_out_reg <= 1'b0;
    end
  end

  // The top bit of the word address is dropped. Only the three low bits
  // count, so a long page write wraps within its page and never spills
  // into the next one.
  // The commit does not move the pointer. The shared read path therefore
  // sees the pointer where the last data byte left it.
  // Address pointer: loaded by the word address, low bits step per byte.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      addr_ptr_reg <= ADDR_RESET;
    end else if (ce_i && byte_done) begin
      if (state_reg == EES_ADDR) begin
        addr_ptr_reg <= rx_byte[ADDR_W-1:0];
      end else if (state_reg == EES_DATA) begin
        addr_ptr_reg <= {addr_ptr_reg[ADDR_W-1:IDX_W],
                         addr_ptr_reg[IDX_W-1:0] + 3'h1};
      end
    end
  end

  // Each slot keeps the last byte written to it and has a valid bit.
  // The valid bits are cleared when a control byte is accepted. As a
  // result, the commit writes only the bytes of the current transfer.
  // When more than eight bytes arrive, the pointer comes round to the
  // oldest slot first. Overwrites therefore follow first-in first-out
  // order.
  // Page buffer slots; the newest byte for a slot replaces the oldest.
  generate
    for (genvar i = 0; i < PAGE_BYTES; i++) begin : g_slot
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          page_mem_reg[i]   <= 8'h00;
          slot_valid_reg[i] <= 1'b0;
        end else if (ce_i && byte_done) begin
          if (state_reg == EES_CTRL && ctrl_match && !busy_reg) begin
            slot_valid_reg[i] <= 1'b0;
          end else if (state_reg == EES_DATA &&
                       addr_ptr_reg[IDX_W-1:0] == IDX_W'(i)) begin
            page_mem_reg[i]   <= rx_byte;
            slot_valid_reg[i] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // A Stop in the data state starts the cycle, but only if at least one
  // byte is buffered and write-protect is low. A Stop right after the
  // address therefore only loads the pointer.
  // The commit steps through slots zero to seven in the first eight busy
  // cycles. It writes one strobe per valid slot, all inside the page.
  // The timer holds busy for the full cycle length, counted from the first
  // commit cycle. While busy is set, control bytes are refused, which lets a
  // master poll for the end of the cycle. The cycle length must be at least
  // the eight commit cycles.
  // Internal write cycle: commit the buffered page, then time out.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy_reg       <= 1'b0;
      timer_reg      <= '0;
      commit_idx_reg <= COMMIT_DONE;
      wr_en_reg      <= 1'b0;
      wr_addr_reg    <= ADDR_RESET;
      wr_data_reg    <= 8'h00;
    end else if (ce_i) begin
      wr_en_reg <= 1'b0;
      if (write_go) begin
        busy_reg       <= 1'b1;
        timer_reg      <= TIMER_W'(WRITE_CYCLES_P - 1);
        commit_idx_reg <= 4'h0;
      end else if (busy_reg) begin
        if (commit_idx_reg < COMMIT_DONE) begin
          wr_en_reg      <= slot_valid_reg[commit_idx_reg[IDX_W-1:0]];
          wr_addr_reg    <= {addr_ptr_reg[ADDR_W-1:IDX_W],
                             commit_idx_reg[IDX_W-1:0]};
          wr_data_reg    <= page_mem_reg[commit_idx_reg[IDX_W-1:0]];
          commit_idx_reg <= commit_idx_reg + 4'h1;
        end
        if (timer_reg == '0) begin
          busy_reg <= 1'b0;
        end else begin
          timer_reg <= timer_reg - TIMER_W'(1);
        end
      end
    end
  end

  // The array port is registered, so the address and data are valid in the
  // same cycle as the write strobe. The memory array samples all three
  // together.
  // Outputs come straight from flip-flops.
  assign sda_o      = sda_out_reg;
  assign sda_oe_o   = sda_oe_reg;
  assign wr_en_o    = wr_en_reg;
  assign wr_addr_o  = wr_addr_reg;
  assign wr_data_o  = wr_data_reg;
  assign addr_ptr_o = addr_ptr_reg;
  assign busy_o     = busy_reg;

endmodule // ees_slave

`default_nettype wire

//--- tb/ees_slave_properties.sv
`timescale 1ns/100ps
`default_nettype none

module ees_slave_props
  import ees_pkg::*;
#(
  parameter int WRITE_CYCLES_P = WRITE_CYCLES
) (
  // Clock and reset.
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // Bus and pin levels.
  input  wire logic              scl_i,
  input  wire logic              sda_o,
  input  wire logic              sda_oe_o,
  input  wire logic              wp_i,
  // Array port and shared state.
  input  wire logic              wr_en_o,
  input  wire logic [ADDR_W-1:0] wr_addr_o,
  input  wire logic [ADDR_W-1:0] addr_ptr_o,
  input  wire logic              busy_o
);
  int busy_cnt;

  // Counts the cycles of the running internal write.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_drive_scl_low: assert property ((sda_oe_o != $past(sda_oe_o)) |-> !scl_i)
    else $error("SDA drive changed while SCL high");
  a_ack_stays_low: assert property ((sda_oe_o && scl_i) |=> (sda_oe_o || !scl_i))
    else $error("Acknowledge released during SCL high");
  a_ack_pulls_low: assert property (sda_oe_o |-> (sda_o == 1'b0))
    else $error("Acknowledge drives a high level");
  a_busy_no_ack: assert property (busy_o |-> !$rose(sda_oe_o))
    else $error("Acknowledge while write cycle runs");
  a_wp_no_write: assert property ((wp_i && $past(wp_i, 4)) |-> !wr_en_o && !$rose(busy_o))
    else $error("Array written under write protect");
  a_write_in_cycle: assert property (wr_en_o |-> busy_o)
    else $error("Array write outside write cycle");
  a_commit_burst: assert property ($rose(busy_o) |-> ##[1:8] wr_en_o)
    else $error("Write cycle without commit");
  a_page_fixed: assert property (wr_en_o |-> (wr_addr_o[6:3] == addr_ptr_o[6:3]))
    else $error("Commit left the current page");
  a_cycle_length: assert property (busy_cnt <= WRITE_CYCLES_P)
    else $error("Write cycle too long");
endmodule // ees_slave_props

bind ees_slave ees_slave_props #(.WRITE_CYCLES_P(WRITE_CYCLES_P)) ees_slave_props_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .wp_i(wp_i), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o), .addr_ptr_o(addr_ptr_o),
  .busy_o(busy_o)
);

`default_nettype wire

//--- tb/ees_master.sv
`timescale 1ns/100ps
`default_nettype none

module ees_master (
  // Pacing clock and bus level.
  input  wire logic clk_i,
  input  wire logic sda_i,
  // Clock line and open-drain pull.
  output logic      scl_o,
  output logic      sda_low_o
);
  // Bus idle with both lines high until a command begins.
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
  end

  // Half of one SCL period at 1 MHz, and a short hold after a fall.
  task automatic w;
    repeat (50) @(posedge clk_i);
  endtask

  task automatic h;
    repeat (5) @(posedge clk_i);
  endtask

  // SDA falls while SCL stays high.
  task automatic start;
    sda_low_o <= 1'b1;
    w();
    scl_o <= 1'b0;
    h();
  endtask

  // SDA rises while SCL stays high.
  task automatic stop;
    sda_low_o <= 1'b1;
    w();
    scl_o <= 1'b1;
    w();
    sda_low_o <= 1'b0;
    w();
  endtask

  // Eight bits MSB first, then a released ninth pulse for the acknowledge.
  task automatic xbyte(input logic [7:0] d, output logic ack, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sda_low_o <= ~d[i];
      w();
      scl_o <= 1'b1;
      w();
      r[i] = sda_i;
      scl_o <= 1'b0;
      h();
    end
    sda_low_o <= 1'b0;
    w();
    scl_o <= 1'b1;
    w();
    ack = ~sda_i;
    scl_o <= 1'b0;
    h();
  endtask
endmodule // ees_master

`default_nettype wire

//--- tb/ees_slave_tb.sv
`timescale 1ns/100ps
`default_nettype none

module ees_slave_tb;
  import ees_pkg::*;
  localparam int WCYC = 2000;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              wp = 1'b0;
  logic              scl;
  logic              m_low;
  wire logic         sda;
  logic              sda_o;
  logic              sda_oe;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [BYTE_W-1:0] wr_data;
  logic [ADDR_W-1:0] ptr;
  logic              busy;
  logic [7:0]        mem [128];
  int                nwr = 0;
  int                miscompares = 0;
  int                checks = 0;

  // Clock and the pulled-up SDA wire.
  always #5 mclk = ~mclk;
  assign sda = ~(sda_oe | m_low);

  ees_slave #(.WRITE_CYCLES_P(WCYC)) ees_slave_inst (
    .mclk_i(mclk), .rst_n_i(rst_n), .ce_i(1'b1), .scl_clk_i(scl), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .addr_ptr_o(ptr), .busy_o(busy)
  );

  ees_master ees_master_inst (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_low_o(m_low));

  // Records every array write as a memory image.
  always @(posedge mclk) begin
    if (wr_en === 1'b1) begin
      mem[wr_addr] <= wr_data;
      nwr++;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Waits, bounded, for the write cycle to end.
  task automatic wait_idle;
    for (int i = 0; i < 3 * WCYC && busy !== 1'b0; i++) @(posedge mclk);
    chk(busy, 1'b0);
  endtask

  // Start, control, address and n data bytes base+k, each ack compared, then Stop.
  task automatic wr(input logic [7:0] ctl, adr, base, input int n, input logic ak);
    logic a;
    logic [7:0] r;
    ees_master_inst.start();
    ees_master_inst.xbyte(ctl, a, r);
    chk(a, 1'b1);
    ees_master_inst.xbyte(adr, a, r);
    chk(a, ak);
    for (int k = 0; k < n; k++) begin
      ees_master_inst.xbyte(base + 8'(k), a, r);
      chk(a, ak);
    end
    ees_master_inst.stop();
  endtask

  // Byte write with address bit 7 set, then a control byte while busy.
  task automatic t_byte;
    logic a;
    logic [7:0] r;
    wr(8'ha0, 8'h92, 8'h5a, 1, 1'b1);
    chk(8'(ptr), 8'h13);
    ees_master_inst.start();
    ees_master_inst.xbyte(8'ha0, a, r);
    chk(a, 1'b0);
    ees_master_inst.stop();
    wait_idle();
    chk(mem[7'h12], 8'h5a);
    chk(8'(nwr), 8'h01);
  endtask

  // Ten bytes from slot 6: wraps inside the page, last eight kept.
  task automatic t_page;
    int s;
    wr(8'hae, 8'h1e, 8'h30, 10, 1'b1);
    chk(8'(ptr), 8'h18);
    wait_idle();
    for (int t = 0; t < 8; t++) begin
      s = (t + 2) % 8;
      chk(mem[7'h18 + 7'(t)], 8'h30 + 8'(s < 2 ? s + 8 : s));
    end
    chk(8'(nwr), 8'h09);
  endtask

  // Protected write is acknowledged yet starts no cycle.
  task automatic t_wp;
    @(posedge mclk) wp <= 1'b1;
    wr(8'ha0, 8'h40, 8'h77, 1, 1'b1);
    repeat (100) @(posedge mclk);
    chk(busy, 1'b0);
    chk(8'(nwr), 8'h09);
    @(posedge mclk) wp <= 1'b0;
  endtask

  // Foreign control code is not acknowledged and the rest is ignored.
  task automatic t_foreign;
    logic a;
    logic [7:0] r;
    ees_master_inst.start();
    ees_master_inst.xbyte(8'hb0, a, r);
    chk(a, 1'b0);
    ees_master_inst.xbyte(8'ha0, a, r);
    chk(a, 1'b0);
    ees_master_inst.stop();
  endtask

  // Read control is acknowledged and SDA is left released.
  task automatic t_read;
    logic a;
    logic [7:0] r;
    ees_master_inst.start();
    ees_master_inst.xbyte(8'ha1, a, r);
    chk(a, 1'b1);
    ees_master_inst.xbyte(8'hff, a, r);
    chk(r, 8'hff);
    ees_master_inst.stop();
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (8) @(posedge mclk);
    t_byte();
    t_page();
    t_wp();
    t_foreign();
    t_read();
    close_out();
  end

  // Cuts a hang short.
  initial begin
    repeat (90000) @(posedge mclk);
    miscompares++;
    close_out();
  end
endmodule // ees_slave_tb

`default_nettype wire
